// File: src/mute_diag_pkg.sv
// package for the mute state sequencer and diagnostic encoder
// assumes a single 100 MHz clock domain
`default_nettype none
package mute_diag_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned PAIR_GAP_MS = 3000;
    localparam int unsigned CURTAIN_GAP_MS = 300;
    localparam int unsigned SENSOR_MUTE_S = 120;
    localparam int unsigned BYPASS_MUTE_S = 600;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned MS_TICK_CYCLES = CYC_PER_MS;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned SYNC_STAGES = 2;

    // display codes, two bcd digits
    localparam logic [7:0] CODE_RUN = 8'h00;
    localparam logic [7:0] CODE_INTERLOCK = 8'h01;
    localparam logic [7:0] CODE_MUTING = 8'h02;
    localparam logic [7:0] CODE_BYPASS = 8'h03;
    localparam logic [7:0] CODE_POWERUP = 8'h88;
    localparam logic [7:0] CODE_INT_FAULT = 8'h50;
    localparam logic [7:0] CODE_EDM_BEFORE = 8'h41;
    localparam logic [7:0] CODE_EDM_AFTER = 8'h42;
    localparam logic [7:0] CODE_EDM_POWERUP = 8'h43;
    localparam logic [7:0] CODE_CH_SEQ = 8'h61;
    localparam logic [7:0] CODE_CH_PAIR = 8'h63;
    localparam logic [7:0] CODE_CH_TIME = 8'h65;
    localparam logic [7:0] CODE_LAMP_OPEN = 8'h67;
    localparam logic [7:0] CODE_CURTAIN = 8'h71;

    typedef struct packed {
        logic mode_invalid;
        logic changed;
        logic banks_differ;
        logic input_count_bad;
        logic sensor_count_bad;
    } switch_fault_t;

    typedef struct packed {
        logic shorted_together;
        logic a_to_power;
        logic b_to_power;
        logic a_to_ground;
        logic b_to_ground;
    } output_fault_t;

    // two channel sensors: first, second of each pair, and the third
    typedef struct packed {
        logic [1:0] first;
        logic [1:0] second;
        logic [1:0] third;
    } sensors_t;

    typedef enum logic [2:0] {
        ST_POWERUP, ST_INTERLOCK, ST_RUN, ST_STOP_BYPASS, ST_MUTE_BYPASS,
        ST_MUTE_SENSOR, ST_STOP
    } mode_t;
endpackage : mute_diag_pkg
`default_nettype wire

// File: src/mute_state_diag_encoder.sv
// state sequencer and diagnostic code encoder of a light curtain mute controller
// every input but clock and reset is asynchronous and passes two flip-flops; one 100 MHz clock
`default_nettype none
module mute_state_diag_encoder #(
    parameter int unsigned MS_CYCLES = mute_diag_pkg::MS_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire mute_diag_pkg::sensors_t sensors_i,
    input wire logic [3:0] curtain_i,
    input wire logic feedback_ok_i,
    input wire logic [1:0] lamp_open_i,
    input wire logic internal_fault_i,
    input wire logic bypass_enable_i,
    input wire mute_diag_pkg::switch_fault_t switch_fault_i,
    input wire mute_diag_pkg::output_fault_t output_fault_i,
    output logic [1:0] safety_switching_output_o,
    output logic [1:0] mute_lamp_o,
    output logic mute_aux_o,
    output logic [7:0] display_o
);
    import mute_diag_pkg::*;

    localparam int SW = $bits(sensors_t) + 4 + 1 + 2 + 1 + 1 + 1 + $bits(switch_fault_t)
        + $bits(output_fault_t);

    // two-stage synchroniser on every pin except clock and reset
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {sensors_i, curtain_i, start_i, lamp_open_i, feedback_ok_i,
                      internal_fault_i, bypass_enable_i, switch_fault_i, output_fault_i};
            sync2 <= sync1;
        end
    end

    sensors_t sens;
    logic [3:0] curt;
    logic start_s;
    logic [1:0] lamp_open;
    logic fb_ok;
    logic int_fault;
    logic byp_en;
    switch_fault_t swf;
    output_fault_t outf;
    assign {sens, curt, start_s, lamp_open, fb_ok, int_fault, byp_en, swf, outf} = sync2;

    // millisecond tick from the system clock
    logic [$clog2(MS_CYCLES+1)-1:0] div;
    wire ms_tick = (div == '0);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) div <= '0;
        else div <= ms_tick ? ($bits(div))'(MS_CYCLES - 1) : div - 1'b1;
    end

    // power-up lasts until the synchroniser holds real pin values, not its reset zeros
    logic [1:0] settle;
    wire settled = (settle == 2'(SYNC_STAGES));
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) settle <= '0;
        else if (!settled) settle <= settle + 2'h1;
    end

    function automatic logic [19:0] bump(input logic [19:0] c, input logic run);
        bump = run ? ((c == '1) ? c : c + 20'h00001) : 20'h00000;
    endfunction : bump

    // curtain state: both inputs of a pair on; skew when they disagree
    wire [1:0] curt_clear = {&curt[3:2], &curt[1:0]};
    wire [1:0] curt_skew = {^curt[3:2], ^curt[1:0]};
    wire curtain_clear = &curt_clear;
    wire [1:0] ch_first = sens.first;
    wire [1:0] ch_second = sens.second;
    wire any_sensor = |{sens.first, sens.second, sens.third};
    wire [1:0] pair_both = ch_first & ch_second;
    wire [1:0] pair_one = ch_first ^ ch_second;

    mode_t mode;
    mode_t next_mode;
    logic third_at_powerup;
    logic start_prev;
    logic rearmed;
    logic [19:0] skew_ms [2];
    logic [19:0] gap_ms [2];
    logic [19:0] mute_ms;
    logic [9:0] blink_ms;
    logic blink;
    logic [1:0] seq_err;
    logic [1:0] pair_err;
    logic [1:0] time_err;
    logic [1:0] curt_err;
    logic [1:0] mute_ch;
    logic fb_err_run;
    logic fb_err_pre;
    logic fb_err_pwr;

    wire start_release = start_prev & ~start_s; // act on the release edge
    // second sensor before first is a bad order for that channel
    wire [1:0] bad_order = ch_second & ~ch_first & {2{~rearmed}} | ch_second & ~ch_first;
    wire [1:0] sensor_mute_ok = pair_both & ~seq_err & ~pair_err & ~lamp_open;
    wire bypass_mute_ms = (mute_ms >= 20'(BYPASS_MUTE_S * MS_PER_S));
    wire sensor_mute_ms = (mute_ms >= 20'(SENSOR_MUTE_S * MS_PER_S));
    wire any_fault = int_fault | (|swf) | (|outf) | fb_err_run | fb_err_pre | fb_err_pwr;

    // state sequencing
    always_comb begin
        next_mode = mode;
        unique case (mode)
            ST_POWERUP: if (settled) next_mode = ST_INTERLOCK;
            ST_INTERLOCK: if (start_release && curtain_clear && fb_ok && !any_fault)
                next_mode = ST_RUN;
            ST_RUN: begin
                if (!curtain_clear) begin
                    if (!third_at_powerup && rearmed && (|sensor_mute_ok))
                        next_mode = ST_MUTE_SENSOR;
                    else if (byp_en && any_sensor)
                        next_mode = ST_STOP_BYPASS;
                    else
                        next_mode = ST_STOP;
                end
            end
            ST_STOP_BYPASS: begin
                if (start_release && !(|lamp_open)) next_mode = ST_MUTE_BYPASS;
                else if (curtain_clear) next_mode = ST_INTERLOCK;
            end
            ST_MUTE_BYPASS: begin
                if (curtain_clear) next_mode = ST_RUN;
                else if (!any_sensor) next_mode = ST_STOP;
                else if (bypass_mute_ms) next_mode = ST_STOP_BYPASS;
            end
            ST_MUTE_SENSOR: begin
                if (curtain_clear) next_mode = ST_RUN;
                else if (!any_sensor || sensor_mute_ms) next_mode = ST_STOP;
            end
            ST_STOP: if (start_release && curtain_clear) next_mode = ST_RUN;
            default: next_mode = ST_INTERLOCK;
        endcase
        if (any_fault && mode != ST_POWERUP) next_mode = ST_INTERLOCK;
    end

    // mode register and power-up snapshot of the third sensor
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode <= ST_POWERUP;
            third_at_powerup <= 1'b0;
            start_prev <= 1'b0;
        end else begin
            mode <= next_mode;
            start_prev <= start_s;
            if (mode == ST_POWERUP && settled) third_at_powerup <= |sens.third;
        end
    end

    // auto muting re-arms once every sensor is clear in run
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) rearmed <= 1'b0;
        else if (mode == ST_RUN && !any_sensor) rearmed <= 1'b1;
        else if (mode == ST_MUTE_BYPASS || mode == ST_MUTE_SENSOR) rearmed <= 1'b0;
    end

    // mute duration counter restarts on every entry into muting
    wire muting = (mode == ST_MUTE_BYPASS) || (mode == ST_MUTE_SENSOR);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) mute_ms <= '0;
        else if (!muting) mute_ms <= '0;
        else if (ms_tick) mute_ms <= bump(mute_ms, 1'b1);
    end

    // per-channel skew timers: sensor pair gap and curtain input pair
    for (genvar c = 0; c < 2; c++) begin : g_ch
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                gap_ms[c] <= '0;
                skew_ms[c] <= '0;
            end else if (ms_tick) begin
                gap_ms[c] <= bump(gap_ms[c], pair_one[c]);
                skew_ms[c] <= bump(skew_ms[c], curt_skew[c]);
            end
        end
        // sticky mute errors, cleared once all sensors are clear again; curtain skew error cleared on start release
        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                seq_err[c] <= 1'b0;
                pair_err[c] <= 1'b0;
                time_err[c] <= 1'b0;
                curt_err[c] <= 1'b0;
                mute_ch[c] <= 1'b0;
            end else begin
                if (bad_order[c] && pair_one[c]) seq_err[c] <= 1'b1;
                else if (!any_sensor) seq_err[c] <= 1'b0;
                if (gap_ms[c] > 20'(PAIR_GAP_MS)) pair_err[c] <= 1'b1;
                else if (!any_sensor) pair_err[c] <= 1'b0;
                if (mode == ST_MUTE_SENSOR && sensor_mute_ms && mute_ch[c])
                    time_err[c] <= 1'b1;
                else if (!any_sensor) time_err[c] <= 1'b0;
                if (skew_ms[c] > 20'(CURTAIN_GAP_MS)) curt_err[c] <= 1'b1;
                else if (start_release) curt_err[c] <= 1'b0;
                if (mode == ST_RUN && next_mode == ST_MUTE_SENSOR)
                    mute_ch[c] <= sensor_mute_ok[c];
            end
        end
    end

    // contactor feedback must match the outputs; classified by phase
    wire outputs_on = (mode == ST_RUN) || muting;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fb_err_pwr <= 1'b0;
            fb_err_pre <= 1'b0;
            fb_err_run <= 1'b0;
        end else begin
            if (mode == ST_POWERUP && settled && !fb_ok) fb_err_pwr <= 1'b1;
            if (mode == ST_INTERLOCK && start_release && !fb_ok) fb_err_pre <= 1'b1;
            if (outputs_on && !fb_ok) fb_err_run <= 1'b1;
        end
    end

    // roughly 1 Hz blink for bypass waiting
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blink_ms <= '0;
            blink <= 1'b0;
        end else if (mode != ST_STOP_BYPASS) begin
            blink_ms <= '0;
            blink <= 1'b1;
        end else if (ms_tick) begin
            if (blink_ms >= 10'(BLINK_HALF_MS - 1)) begin
                blink_ms <= '0;
                blink <= ~blink;
            end else blink_ms <= blink_ms + 10'h001;
        end
    end

    // code select: internal, switch, output, feedback, curtain, mute, status
    logic [7:0] next_code;
    always_comb begin
        next_code = CODE_RUN;
        if (int_fault) next_code = CODE_INT_FAULT;
        else if (swf.mode_invalid) next_code = 8'h21;
        else if (swf.changed) next_code = 8'h22;
        else if (swf.banks_differ) next_code = 8'h23;
        else if (swf.input_count_bad) next_code = 8'h27;
        else if (swf.sensor_count_bad) next_code = 8'h28;
        else if (outf.shorted_together) next_code = 8'h31;
        else if (outf.a_to_power) next_code = 8'h32;
        else if (outf.b_to_power) next_code = 8'h33;
        else if (outf.a_to_ground) next_code = 8'h34;
        else if (outf.b_to_ground) next_code = 8'h35;
        else if (fb_err_pwr) next_code = CODE_EDM_POWERUP;
        else if (fb_err_pre) next_code = CODE_EDM_BEFORE;
        else if (fb_err_run) next_code = CODE_EDM_AFTER;
        else if (|curt_err) next_code = CODE_CURTAIN + {7'h00, ~curt_err[0]};
        else if (|lamp_open) next_code = CODE_LAMP_OPEN + {7'h00, ~lamp_open[0]};
        else if (|time_err) next_code = CODE_CH_TIME + {7'h00, ~time_err[0]};
        else if (|pair_err) next_code = CODE_CH_PAIR + {7'h00, ~pair_err[0]};
        else if (|seq_err) next_code = CODE_CH_SEQ + {7'h00, ~seq_err[0]};
        else if (mode == ST_POWERUP) next_code = CODE_POWERUP;
        else if (mode == ST_INTERLOCK || mode == ST_STOP) next_code = CODE_INTERLOCK;
        else if (mode == ST_STOP_BYPASS) next_code = CODE_BYPASS;
        else if (mode == ST_MUTE_BYPASS) next_code = CODE_MUTING;
        else if (mode == ST_MUTE_SENSOR) next_code = CODE_MUTING;
    end

    // registered outputs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            display_o <= CODE_POWERUP;
            safety_switching_output_o <= 2'h0;
            mute_lamp_o <= 2'h0;
            mute_aux_o <= 1'b0;
        end else begin
            display_o <= next_code;
            safety_switching_output_o <= {2{outputs_on & ~any_fault}};
            mute_lamp_o <= muting ? 2'h3 : (mode == ST_STOP_BYPASS) ? {2{blink}} : 2'h0;
            mute_aux_o <= muting | ((mode == ST_STOP_BYPASS) & blink);
        end
    end
endmodule : mute_state_diag_encoder
`default_nettype wire

// File: sim/mute_state_diag_encoder_assertions.sv
// concurrent checks on the mute sequencer ports, bound into every instance
// assumes one clock domain and the package display codes
`default_nettype none
module mute_state_diag_encoder_assertions
#(
    parameter int unsigned MS_CYCLES = 10
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic feedback_ok_i,
    input wire logic internal_fault_i,
    input wire mute_diag_pkg::switch_fault_t switch_fault_i,
    input wire mute_diag_pkg::output_fault_t output_fault_i,
    input wire logic [1:0] safety_switching_output_o,
    input wire logic [1:0] mute_lamp_o,
    input wire logic mute_aux_o,
    input wire logic [7:0] display_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import mute_diag_pkg::*;
    localparam int BLINK_MAX = 500 * MS_CYCLES + 8;
    int aux_run;
    logic aux_last;
    logic clean;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // no fault input at all, so status codes are expected
    assign clean = !internal_fault_i && feedback_ok_i && switch_fault_i == '0
        && output_fault_i == '0;

    // cycles since the aux output last flipped while bypass waits
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aux_run <= 0;
            aux_last <= 1'b0;
        end else begin
            aux_last <= mute_aux_o;
            aux_run <= (display_o != CODE_BYPASS || mute_aux_o != aux_last) ? 0 : aux_run + 1;
        end
    end

    a_powerup_shown: assert property ($rose(reset_n_i) |-> display_o == CODE_POWERUP
        && safety_switching_output_o == 2'b00) else $error("power-up code missing");
    a_interlock_entry: assert property ($rose(reset_n_i) && clean
        |-> ##[1:4] display_o == CODE_INTERLOCK) else $error("interlock not entered");
    a_internal_wins: assert property (internal_fault_i [*4]
        |-> ##[0:2] display_o == CODE_INT_FAULT) else $error("internal fault code wrong");
    a_internal_stops: assert property (internal_fault_i [*4]
        |-> ##[0:2] safety_switching_output_o == 2'b00) else $error("outputs on at fault");
    a_mode_code: assert property ((switch_fault_i.mode_invalid && !internal_fault_i) [*4]
        |-> ##[0:2] display_o == 8'h21) else $error("mode fault code wrong");
    a_short_code: assert property ((output_fault_i.shorted_together && !internal_fault_i
        && switch_fault_i == '0) [*4] |-> ##[0:2] display_o == 8'h31) else $error("short code");
    a_outputs_paired: assert property (safety_switching_output_o[0]
        == safety_switching_output_o[1]) else $error("safety outputs differ");
    a_interlock_off: assert property (display_o == CODE_INTERLOCK
        |-> safety_switching_output_o == 2'b00) else $error("outputs on in interlock");
    a_bypass_off: assert property (display_o == CODE_BYPASS
        |-> safety_switching_output_o == 2'b00) else $error("outputs on in bypass wait");
    a_muting_lit: assert property (display_o == CODE_MUTING |-> safety_switching_output_o
        == 2'b11 && mute_aux_o && mute_lamp_o != 2'b00) else $error("muting outputs wrong");
    a_run_dark: assert property (display_o == CODE_RUN && safety_switching_output_o == 2'b11
        |-> mute_lamp_o == 2'b00) else $error("lamp lit in run");
    a_blink_rate: assert property (aux_run <= BLINK_MAX)
        else $error("aux output stopped blinking");

    c_bypass: cover property (display_o == CODE_BYPASS);
    c_muting: cover property (display_o == CODE_MUTING);
    c_skew: cover property (display_o == 8'h71);
endmodule : mute_state_diag_encoder_assertions

bind mute_state_diag_encoder mute_state_diag_encoder_assertions #(.MS_CYCLES(MS_CYCLES)) chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .feedback_ok_i(feedback_ok_i),
    .internal_fault_i(internal_fault_i), .switch_fault_i(switch_fault_i),
    .output_fault_i(output_fault_i), .safety_switching_output_o(safety_switching_output_o),
    .mute_lamp_o(mute_lamp_o), .mute_aux_o(mute_aux_o), .display_o(display_o));
`default_nettype wire

// File: sim/mute_field_model.sv
// field model: conveyor object, channel one sensors, light curtain, start button
// assumes the bench moves its controls at the falling edge
`default_nettype none
module mute_field_model (
    input wire logic clk_i,
    input wire logic at_sensors_i,
    input wire logic in_curtain_i,
    input wire logic third_i,
    input wire logic skew_i,
    input wire logic lag_i,
    output wire mute_diag_pkg::sensors_t sensors_o,
    output wire logic [3:0] curtain_o,
    output logic start_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import mute_diag_pkg::*;

    // object blocks first and second sensor together; skew drops one beam alone
    // lag holds the first sensor back, so the second one leads in the wrong order
    assign sensors_o = {1'b0, at_sensors_i & ~lag_i, 1'b0, at_sensors_i, 1'b0, third_i};
    assign curtain_o = in_curtain_i ? 4'h0 : {3'b111, ~skew_i};

    initial start_o = 1'b0;

    // held four cycles: only the release counts, so it must be long enough to sync
    task automatic press;
        start_o = 1'b1;
        repeat (4) @(negedge clk_i);
        start_o = 1'b0;
    endtask : press
endmodule : mute_field_model
`default_nettype wire

// File: sim/mute_state_diag_encoder_test.sv
// self-checking bench for the mute sequencer and diagnostic encoder
// assumes the field model drives sensors, curtain and start
`default_nettype none
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
module mute_state_diag_encoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mute_diag_pkg::*;
    localparam int unsigned MS = 10;
    logic clk_i = 0, reset_n_i = 0, feedback_ok_i = 1, internal_fault_i = 0;
    logic bypass_enable_i = 1, at_s = 0, in_c = 0, third = 0, skew = 0, lag = 0, start_i, aux;
    logic [1:0] lamp_open_i = '0, safety, lamp;
    logic [3:0] curtain_i;
    logic [7:0] disp;
    switch_fault_t switch_fault_i = '0;
    output_fault_t output_fault_i = '0;
    sensors_t sensors_i;
    int n_mismatch = 0, checks = 0;

    mute_field_model FIELD (.clk_i(clk_i), .at_sensors_i(at_s), .in_curtain_i(in_c),
        .third_i(third), .skew_i(skew), .lag_i(lag), .sensors_o(sensors_i), .curtain_o(curtain_i),
        .start_o(start_i));
    // shortened millisecond so the 300 ms skew fits the run
    mute_state_diag_encoder #(.MS_CYCLES(MS)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .start_i(start_i), .sensors_i(sensors_i), .curtain_i(curtain_i),
        .feedback_ok_i(feedback_ok_i), .lamp_open_i(lamp_open_i),
        .internal_fault_i(internal_fault_i), .bypass_enable_i(bypass_enable_i),
        .switch_fault_i(switch_fault_i), .output_fault_i(output_fault_i),
        .safety_switching_output_o(safety), .mute_lamp_o(lamp), .mute_aux_o(aux),
        .display_o(disp));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    // five cycles low, then let power-up pass into interlock
    task automatic do_reset;
        reset_n_i = 1'b0;
        cyc(5);
        `CHK("reset code", CODE_POWERUP, disp)
        reset_n_i = 1'b1;
        cyc(6);
    endtask : do_reset

    task automatic set_fault(input int k, input logic v);
        case (k)
            0: internal_fault_i = v;
            1, 2, 3, 4, 5: switch_fault_i[5 - k] = v;
            6, 7, 8, 9, 10: output_fault_i[10 - k] = v;
            11: feedback_ok_i = !v;
            default: skew = v;
        endcase
    endtask : set_fault

    // start refused on a blocked curtain, taken on a clear one
    task automatic t_run;
        do_reset();
        `CHK("interlock code", CODE_INTERLOCK, disp)
        `CHK("outputs at power-up", 2'b00, safety)
        in_c = 1;
        FIELD.press();
        cyc(10);
        `CHK("refused start", CODE_INTERLOCK, disp)
        in_c = 0;
        cyc(2);
        FIELD.press();
        cyc(10);
        `CHK("run code", CODE_RUN, disp)
        `CHK("run outputs", 2'b11, safety)
        feedback_ok_i = 0;
        cyc(10);
        `CHK("feedback in run", CODE_EDM_AFTER, disp)
        feedback_ok_i = 1;
    endtask : t_run

    // third sensor at power-up forces the bypass route through muting
    task automatic t_bypass;
        int n;
        logic a;
        third = 1;
        do_reset();
        FIELD.press();
        third = 0;
        cyc(10);
        `CHK("run before object", CODE_RUN, disp)
        at_s = 1;
        in_c = 1;
        cyc(10);
        `CHK("bypass code", CODE_BYPASS, disp)
        `CHK("bypass outputs", 2'b00, safety)
        n = 0;
        a = aux;
        while (aux === a && n < 5100) begin
            cyc(1);
            n++;
        end
        `CHK("aux blinks", 1'b1, n < 5100)
        FIELD.press();
        cyc(10);
        `CHK("muting code", CODE_MUTING, disp)
        `CHK("muting outputs", 2'b11, safety)
        `CHK("lamp steady", 1'b1, lamp[0])
        `CHK("aux steady", 1'b1, aux)
        in_c = 0;
        cyc(10);
        `CHK("curtain cleared", CODE_RUN, disp)
        `CHK("lamp off", 2'b00, lamp)
        at_s = 0;
        cyc(10);
        `CHK("sensors cleared", CODE_RUN, disp)
        `CHK("still running", 2'b11, safety)
        at_s = 1;
        in_c = 1;
        cyc(10);
        FIELD.press();
        cyc(10);
        `CHK("muting again", CODE_MUTING, disp)
        at_s = 0;
        cyc(10);
        `CHK("sensors clear first", CODE_INTERLOCK, disp)
        `CHK("stopped outputs", 2'b00, safety)
        in_c = 0;
    endtask : t_bypass

    // automatic muting once re-armed, then a wrong order held past the pair gap
    task automatic t_sensor;
        do_reset();
        FIELD.press();
        cyc(10);
        at_s = 1;
        in_c = 1;
        cyc(10);
        `CHK("sensor muting", CODE_MUTING, disp)
        `CHK("sensor muting outputs", 2'b11, safety)
        in_c = 0;
        at_s = 0;
        cyc(10);
        at_s = 1;
        lag = 1;
        cyc(10);
        `CHK("order error", 8'h61, disp)
        cyc(30100);
        `CHK("pair gap error", 8'h63, disp)
        at_s = 0;
        lag = 0;
        cyc(20);
        `CHK("mute errors cleared", CODE_RUN, disp)
        lamp_open_i = 2'b10;
        cyc(10);
        `CHK("lamp two open", 8'h68, disp)
        lamp_open_i = 2'b00;
    endtask : t_sensor

    // one fault at a time from a fresh reset, since feedback faults stay until reset
    task automatic t_faults;
        logic [7:0] code [13] = '{8'h50, 8'h21, 8'h22, 8'h23, 8'h27, 8'h28, 8'h31, 8'h32,
            8'h33, 8'h34, 8'h35, 8'h41, 8'h71};
        for (int k = 0; k < 13; k++) begin
            do_reset();
            set_fault(k, 1'b1);
            // feedback is judged when start is released in interlock
            if (k == 11) FIELD.press();
            if (k == 12) begin
                cyc(2900);
                `CHK("skew under limit", CODE_INTERLOCK, disp)
            end
            cyc(k == 12 ? 200 : 10);
            `CHK("fault code", code[k], disp)
            set_fault(k, 1'b0);
        end
        feedback_ok_i = 0;
        do_reset();
        `CHK("feedback at power-up", CODE_EDM_POWERUP, disp)
        feedback_ok_i = 1;
    endtask : t_faults

    initial begin
        t_run();
        t_bypass();
        t_sensor();
        t_faults();
        finish_test();
    end

    // the tests need about 40000 cycles, most of it the pair gap wait
    initial begin
        repeat (80000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end
endmodule : mute_state_diag_encoder_test
`default_nettype wire
